// ==== core/dps_pkg.sv ====
// Constants, register map and carrier types of the digital positioning sequencer.
// Assumes a 200 MHz APB clock; time parameters are held in 1 ms or 10 ms units as noted.
// Summary of operation
// - Mode bit 1: clear gives terminal-triggered cycles, set gives automatic cycles.
// - Mode bit 4 decides when the home search is carried out.
// - Bit 4 clear searches home once; set searches at every run start.
// - Mode bit 5: clear calibrates home continuously, set calibrates it once.
// - Mode bit 6: clear pulses completion for hold time; set holds it.
// - Terminal mode: bit 7 set moves to initial position, clear stays still.
// - Terminal mode enable is pulse (bit 8 clear) or level; automatic always enabled.
// - Mode bit 9 takes target from digital reference or from fieldbus.
// - Mode bits 10 to 15 are reserved and read as zero.
// - Target equals the selected reference (digital or fieldbus) times gear numerator over gear denominator.
// - Speed source code 0 digital, 1-3 analog inputs, 4-5 fast pulse inputs.
// - Ramp rate follows accel and decel times, 0.01 to 300.00 s, default 3.00 s.
// - After arrival wait the arrival hold time, 0 to 60 s, default 0.100 s.
// - Completion hold time, default 0.200 s, also drives spindle orientation completion.
// - Feedforward filter applies only when a speed source select equals 12.
package dps_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_POSREF = 8'h04;
   localparam logic [7:0] ADDR_SPDSRC = 8'h08;
   localparam logic [7:0] ADDR_SPDDIG = 8'h0c;
   localparam logic [7:0] ADDR_ACCEL = 8'h10;
   localparam logic [7:0] ADDR_DECEL = 8'h14;
   localparam logic [7:0] ADDR_ARRHOLD = 8'h18;
   localparam logic [7:0] ADDR_HOMESPD = 8'h1c;
   localparam logic [7:0] ADDR_HOMEOFS = 8'h20;
   localparam logic [7:0] ADDR_CMPHOLD = 8'h24;
   localparam logic [7:0] ADDR_SUPVAL = 8'h28;
   localparam logic [7:0] ADDR_SUPSPD = 8'h2c;
   localparam logic [7:0] ADDR_RAMPOFF = 8'h30;
   localparam logic [7:0] ADDR_FFFILT = 8'h34;
   localparam logic [7:0] ADDR_GEAR2 = 8'h38;
   localparam logic [7:0] ADDR_GEARNUM = 8'h3c;
   localparam logic [7:0] ADDR_GEARDEN = 8'h40;
   localparam logic [7:0] ADDR_SRCSEL = 8'h44;
   localparam logic [7:0] ADDR_TARGET = 8'h48;
   localparam logic [7:0] ADDR_STATE = 8'h4c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h54;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h58;
   // Mode word fields
   localparam int MB_CYCLE = 1;
   localparam int MB_HOMEMODE = 4;
   localparam int MB_CALIB = 5;
   localparam int MB_CMPSIG = 6;
   localparam int MB_INITPOS = 7;
   localparam int MB_ENLEVEL = 8;
   localparam int MB_SRC = 9;
   localparam logic [15:0] MODE_WMASK = 16'h03ff;
   // Reset values, units: times 10 ms (accel) or 1 ms (holds), filter 0.1 ms
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_SPDDIG = 16'h00c8;
   localparam logic [15:0] RST_ACCEL = 16'h012c;
   localparam logic [15:0] RST_ARRHOLD = 16'h0064;
   localparam logic [15:0] RST_HOMESPD = 16'h00c8;
   localparam logic [15:0] RST_CMPHOLD = 16'h00c8;
   localparam logic [15:0] RST_SUPSPD = 16'h0050;
   localparam logic [15:0] RST_RAMPOFF = 16'h0032;
   localparam logic [15:0] RST_FFFILT = 16'h0064;
   localparam logic [15:0] RST_GEAR = 16'h03e8;
   localparam logic [15:0] ACCEL_MIN = 16'h0001;
   localparam logic [15:0] ACCEL_MAX = 16'h7530;
   localparam logic [15:0] HOLD_MAX = 16'hea60;
   // Speed source codes
   localparam logic [2:0] SRC_DIGITAL = 3'h0;
   localparam logic [2:0] SRC_AI1 = 3'h1;
   localparam logic [2:0] SRC_AI2 = 3'h2;
   localparam logic [2:0] SRC_AI3 = 3'h3;
   localparam logic [2:0] SRC_FPA = 3'h4;
   localparam logic [2:0] SRC_FPB = 3'h5;
   localparam logic [7:0] SRC_PULSE_STRING = 8'h0c;
   // Timing: tick of 1 ms from 200 MHz clock
   localparam int CLK_HZ = 200000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TEN_MS = 10;
   // Interrupt bits
   localparam int IRQ_ARRIVED = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_HOMED = 2;
   localparam int IRQ_W = 3;
   // Analog and pulse speed inputs grouped
   typedef struct packed {
      logic [15:0] analog_input_one;
      logic [15:0] analog_input_two;
      logic [15:0] analog_input_three;
      logic [15:0] fast_pulse_input_a;
      logic [15:0] fast_pulse_input_b;
   } dps_speed_in_t;
   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] ramp_time;
      logic accel;
   } dps_drive_t;
endpackage

// ==== core/dps_sequencer.sv ====
// Digital positioning sequencer with APB register file and interrupt.
// Assumes the motor loop reports arrival and home; terminals come from pins.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module dps_sequencer
   import dps_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run_cmd,
   input wire logic pos_enable_pin,
   input wire logic home_switch_pin,
   input wire logic [15:0] fieldbus_target,
   input wire logic position_reached,
   input wire dps_speed_in_t speed_in,
   output dps_drive_t drive_out,
   output logic [31:0] target_position,
   output logic move_request,
   output logic home_search,
   output logic home_calibrate,
   output logic ff_filter_active,
   output logic [15:0] ff_filter_time,
   output logic positioning_done,
   output logic spindle_done,
   output logic irq
);
   typedef enum {ST_IDLE, ST_HOME, ST_INIT, ST_WAIT_EN, ST_MOVE, ST_ARRIVE} dps_state_t;

   logic [15:0] mode_reg, posref_reg, spdsrc_reg, spddig_reg, accel_reg, decel_reg;
   logic [15:0] arrhold_reg, homespd_reg, homeofs_reg, cmphold_reg, supval_reg;
   logic [15:0] supspd_reg, rampoff_reg, fffilt_reg, gear2_reg, gearnum_reg, gearden_reg;
   logic [15:0] srcsel_reg;
   logic [IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
   dps_state_t state_reg;
   logic [2:0] en_sync_reg, home_sync_reg;
   logic en_prev_reg, homed_reg, calibrated_reg;
   logic [31:0] tick_cnt_reg;
   logic tick;
   logic [15:0] arr_cnt_reg, cmp_cnt_reg;
   logic done_reg;
   logic en_level, en_rise, home_level;
   logic wr, rd;

   // Clamp a time value into its legal range
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;

   // Unmapped addresses answer with an error
   always_comb begin
      case (paddr)
         ADDR_MODE, ADDR_POSREF, ADDR_SPDSRC, ADDR_SPDDIG, ADDR_ACCEL, ADDR_DECEL, ADDR_ARRHOLD,
         ADDR_HOMESPD, ADDR_HOMEOFS, ADDR_CMPHOLD, ADDR_SUPVAL, ADDR_SUPSPD, ADDR_RAMPOFF,
         ADDR_FFFILT, ADDR_GEAR2, ADDR_GEARNUM, ADDR_GEARDEN, ADDR_SRCSEL, ADDR_TARGET,
         ADDR_STATE, ADDR_IRQ_STAT, ADDR_IRQ_EN, ADDR_IRQ_CLR: pslverr = 1'b0;
         default: pslverr = psel && penable;
      endcase
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= RST_ZERO;
         posref_reg <= RST_ZERO;
         spdsrc_reg <= RST_ZERO;
         spddig_reg <= RST_SPDDIG;
         accel_reg <= RST_ACCEL;
         decel_reg <= RST_ACCEL;
         arrhold_reg <= RST_ARRHOLD;
         homespd_reg <= RST_HOMESPD;
         homeofs_reg <= RST_ZERO;
         cmphold_reg <= RST_CMPHOLD;
         supval_reg <= RST_ZERO;
         supspd_reg <= RST_SUPSPD;
         rampoff_reg <= RST_RAMPOFF;
         fffilt_reg <= RST_FFFILT;
         gear2_reg <= RST_GEAR;
         gearnum_reg <= RST_GEAR;
         gearden_reg <= RST_GEAR;
         srcsel_reg <= RST_ZERO;
         irq_en_reg <= '0;
      end else if (wr) begin
         case (paddr)
            ADDR_MODE: mode_reg <= pwdata[15:0] & MODE_WMASK;
            ADDR_POSREF: posref_reg <= pwdata[15:0];
            ADDR_SPDSRC: spdsrc_reg <= pwdata[15:0];
            ADDR_SPDDIG: spddig_reg <= pwdata[15:0];
            ADDR_ACCEL: accel_reg <= clamp(pwdata[15:0], ACCEL_MIN, ACCEL_MAX);
            ADDR_DECEL: decel_reg <= clamp(pwdata[15:0], ACCEL_MIN, ACCEL_MAX);
            ADDR_ARRHOLD: arrhold_reg <= clamp(pwdata[15:0], RST_ZERO, HOLD_MAX);
            ADDR_HOMESPD: homespd_reg <= pwdata[15:0];
            ADDR_HOMEOFS: homeofs_reg <= pwdata[15:0];
            ADDR_CMPHOLD: cmphold_reg <= clamp(pwdata[15:0], RST_ZERO, HOLD_MAX);
            ADDR_SUPVAL: supval_reg <= pwdata[15:0];
            ADDR_SUPSPD: supspd_reg <= pwdata[15:0];
            ADDR_RAMPOFF: rampoff_reg <= pwdata[15:0];
            ADDR_FFFILT: fffilt_reg <= pwdata[15:0];
            ADDR_GEAR2: gear2_reg <= pwdata[15:0];
            ADDR_GEARNUM: gearnum_reg <= (pwdata[15:0] == RST_ZERO) ? ACCEL_MIN : pwdata[15:0];
            ADDR_GEARDEN: gearden_reg <= (pwdata[15:0] == RST_ZERO) ? ACCEL_MIN : pwdata[15:0];
            ADDR_SRCSEL: srcsel_reg <= pwdata[15:0];
            ADDR_IRQ_EN: irq_en_reg <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Read data registered in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd) begin
         case (paddr)
            ADDR_MODE: prdata <= {16'h0000, mode_reg};
            ADDR_POSREF: prdata <= {16'h0000, posref_reg};
            ADDR_SPDSRC: prdata <= {16'h0000, spdsrc_reg};
            ADDR_SPDDIG: prdata <= {16'h0000, spddig_reg};
            ADDR_ACCEL: prdata <= {16'h0000, accel_reg};
            ADDR_DECEL: prdata <= {16'h0000, decel_reg};
            ADDR_ARRHOLD: prdata <= {16'h0000, arrhold_reg};
            ADDR_HOMESPD: prdata <= {16'h0000, homespd_reg};
            ADDR_HOMEOFS: prdata <= {16'h0000, homeofs_reg};
            ADDR_CMPHOLD: prdata <= {16'h0000, cmphold_reg};
            ADDR_SUPVAL: prdata <= {16'h0000, supval_reg};
            ADDR_SUPSPD: prdata <= {16'h0000, supspd_reg};
            ADDR_RAMPOFF: prdata <= {16'h0000, rampoff_reg};
            ADDR_FFFILT: prdata <= {16'h0000, fffilt_reg};
            ADDR_GEAR2: prdata <= {16'h0000, gear2_reg};
            ADDR_GEARNUM: prdata <= {16'h0000, gearnum_reg};
            ADDR_GEARDEN: prdata <= {16'h0000, gearden_reg};
            ADDR_SRCSEL: prdata <= {16'h0000, srcsel_reg};
            ADDR_TARGET: prdata <= target_position;
            ADDR_STATE: prdata <= {27'h0, homed_reg, calibrated_reg, 3'(state_reg)};
            ADDR_IRQ_STAT: prdata <= {29'h0, irq_stat_reg};
            ADDR_IRQ_EN: prdata <= {29'h0, irq_en_reg};
            default: prdata <= '0;
         endcase
      end
   end

   // Pin synchronisers: change accepted when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_sync_reg <= '0;
         home_sync_reg <= '0;
         en_level <= 1'b0;
         home_level <= 1'b0;
      end else begin
         en_sync_reg <= {en_sync_reg[1:0], pos_enable_pin};
         home_sync_reg <= {home_sync_reg[1:0], home_switch_pin};
         if (en_sync_reg[1] == en_sync_reg[2])
            en_level <= en_sync_reg[2];
         if (home_sync_reg[1] == home_sync_reg[2])
            home_level <= home_sync_reg[2];
      end
   end

   // Enable edge detector for pulse mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         en_prev_reg <= 1'b0;
      else
         en_prev_reg <= en_level;
   end
   assign en_rise = en_level && !en_prev_reg;

   // Millisecond tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt_reg <= '0;
      else if (tick_cnt_reg == 32'(TICK_DIV - 1))
         tick_cnt_reg <= '0;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
   end
   assign tick = (tick_cnt_reg == 32'(TICK_DIV - 1));

   // Electronic gear scaling of the selected target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         target_position <= '0;
      else if (mode_reg[MB_SRC])
         target_position <= (32'(fieldbus_target) * 32'(gearnum_reg)) / 32'(gearden_reg);
      else
         target_position <= (32'(posref_reg) * 32'(gearnum_reg)) / 32'(gearden_reg);
   end

   // Speed source and ramp selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_out <= '0;
      end else begin
         case (spdsrc_reg[2:0])
            SRC_DIGITAL: drive_out.speed <= spddig_reg;
            SRC_AI1: drive_out.speed <= speed_in.analog_input_one;
            SRC_AI2: drive_out.speed <= speed_in.analog_input_two;
            SRC_AI3: drive_out.speed <= speed_in.analog_input_three;
            SRC_FPA: drive_out.speed <= speed_in.fast_pulse_input_a;
            SRC_FPB: drive_out.speed <= speed_in.fast_pulse_input_b;
            default: drive_out.speed <= spddig_reg;
         endcase
         if (state_reg == ST_HOME)
            drive_out.speed <= homespd_reg;
         drive_out.accel <= (state_reg != ST_ARRIVE);
         drive_out.ramp_time <= (state_reg == ST_ARRIVE) ? decel_reg : accel_reg;
      end
   end

   // Feedforward filter only in pulse-string speed mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff_filter_active <= 1'b0;
         ff_filter_time <= '0;
      end else begin
         ff_filter_active <= (srcsel_reg[7:0] == SRC_PULSE_STRING) ||
                             (srcsel_reg[15:8] == SRC_PULSE_STRING);
         ff_filter_time <= fffilt_reg;
      end
   end

   // Positioning sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         homed_reg <= 1'b0;
         calibrated_reg <= 1'b0;
         arr_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: if (run_cmd) begin
               if (!homed_reg || mode_reg[MB_HOMEMODE])
                  state_reg <= ST_HOME;
               else if (!mode_reg[MB_CYCLE] && mode_reg[MB_INITPOS])
                  state_reg <= ST_INIT;
               else
                  state_reg <= ST_WAIT_EN;
            end
            ST_HOME: if (home_level) begin
               homed_reg <= 1'b1;
               calibrated_reg <= 1'b1;
               state_reg <= (!mode_reg[MB_CYCLE] && mode_reg[MB_INITPOS]) ? ST_INIT : ST_WAIT_EN;
            end
            ST_INIT: if (position_reached)
               state_reg <= ST_WAIT_EN;
            ST_WAIT_EN: begin
               if (!run_cmd)
                  state_reg <= ST_IDLE;
               else if (mode_reg[MB_CYCLE] || (mode_reg[MB_ENLEVEL] ? en_level : en_rise))
                  state_reg <= ST_MOVE;
            end
            ST_MOVE: if (position_reached) begin
               state_reg <= ST_ARRIVE;
               arr_cnt_reg <= '0;
            end
            ST_ARRIVE: begin
               if (arr_cnt_reg >= arrhold_reg)
                  state_reg <= ST_WAIT_EN;
               else if (tick)
                  arr_cnt_reg <= arr_cnt_reg + 16'h1;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Motion requests toward the drive
   assign move_request = (state_reg == ST_MOVE) || (state_reg == ST_INIT);
   assign home_search = (state_reg == ST_HOME);
   // Real-time calibration follows the switch; single mode only until first home
   assign home_calibrate = home_level && (!mode_reg[MB_CALIB] || !calibrated_reg);

   // Completion signal timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         cmp_cnt_reg <= '0;
      end else if (state_reg == ST_MOVE && position_reached) begin
         done_reg <= 1'b1;
         cmp_cnt_reg <= '0;
      end else if (state_reg == ST_MOVE) begin
         done_reg <= 1'b0;
      end else if (done_reg && !mode_reg[MB_CMPSIG]) begin
         if (cmp_cnt_reg >= cmphold_reg)
            done_reg <= 1'b0;
         else if (tick)
            cmp_cnt_reg <= cmp_cnt_reg + 16'h1;
      end
   end
   assign positioning_done = done_reg;
   assign spindle_done = done_reg;

   // Sticky interrupt status, set wins over clear
   assign irq_set[IRQ_ARRIVED] = (state_reg == ST_MOVE) && position_reached;
   assign irq_set[IRQ_DONE] = done_reg && !mode_reg[MB_CMPSIG] && (cmp_cnt_reg >= cmphold_reg);
   assign irq_set[IRQ_HOMED] = (state_reg == ST_HOME) && home_level;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_stat_reg <= '0;
      else if (wr && paddr == ADDR_IRQ_CLR)
         irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // Checks
   AST_REPEAT_HOME: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && run_cmd && mode_reg[MB_HOMEMODE] |=> state_reg == ST_HOME)
      else $error("home search not repeated");
   AST_AUTO_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_WAIT_EN && run_cmd && mode_reg[MB_CYCLE] |=> state_reg == ST_MOVE)
      else $error("automatic cycle not enabled");
   AST_PULSE_EN: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_WAIT_EN && !mode_reg[MB_CYCLE] && !mode_reg[MB_ENLEVEL] && !en_rise |=>
      state_reg != ST_MOVE)
      else $error("move without enable pulse");
   AST_DONE_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      done_reg && mode_reg[MB_CMPSIG] && state_reg != ST_MOVE && $stable(mode_reg) |=> done_reg)
      else $error("completion dropped in level mode");
   AST_TARGET: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_reg[MB_SRC] && $stable(posref_reg) && $stable(gearnum_reg) && $stable(gearden_reg)
      && !$past(mode_reg[MB_SRC]) |->
      target_position == (32'(posref_reg) * 32'(gearnum_reg)) / 32'(gearden_reg))
      else $error("gear scaling wrong");
   AST_FF: assert property (@(posedge pclk) disable iff (!presetn)
      srcsel_reg[7:0] != SRC_PULSE_STRING && srcsel_reg[15:8] != SRC_PULSE_STRING && $stable(srcsel_reg)
      |=> !ff_filter_active)
      else $error("filter active outside pulse mode");
   AST_ARRIVE: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_ARRIVE && arr_cnt_reg < arrhold_reg |=> state_reg == ST_ARRIVE)
      else $error("arrival hold cut short");
   AST_ACCEL: assert property (@(posedge pclk) disable iff (!presetn)
      accel_reg >= ACCEL_MIN && accel_reg <= ACCEL_MAX)
      else $error("accel time out of range");
   // Terminal-cycle entry and enable, completion pulse, speed source and ramp direction
   AST_INIT_POS: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && run_cmd && homed_reg && !mode_reg[MB_HOMEMODE]
      && !mode_reg[MB_CYCLE] && mode_reg[MB_INITPOS] |=> state_reg == ST_INIT)
      else $error("initial move skipped");
   AST_LEVEL_EN: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_WAIT_EN && run_cmd && !mode_reg[MB_CYCLE] && mode_reg[MB_ENLEVEL] && en_level |=>
      state_reg == ST_MOVE)
      else $error("level enable ignored");
   AST_DONE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      done_reg && !mode_reg[MB_CMPSIG] && cmp_cnt_reg >= cmphold_reg && state_reg != ST_MOVE |=> !done_reg)
      else $error("completion outlived hold time");
   AST_SRC_DIGITAL: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg != ST_HOME && spdsrc_reg[2:0] == SRC_DIGITAL |=> drive_out.speed == $past(spddig_reg))
      else $error("digital speed not selected");
   AST_RAMP_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_ARRIVE |=> !drive_out.accel && drive_out.ramp_time == $past(decel_reg))
      else $error("deceleration time not applied");
   AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      irq_set[IRQ_ARRIVED] |=> irq_stat_reg[IRQ_ARRIVED])
      else $error("arrival status lost");
   COV_MOVE: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_MOVE ##1 state_reg == ST_ARRIVE);
   COV_HOME: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_HOME ##1 state_reg == ST_WAIT_EN);
   COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   COV_INIT: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_INIT ##1 state_reg == ST_WAIT_EN);
endmodule

// ==== bench/dps_motor_model.sv ====
// Motor and feedback model: arrival and home switch answer after a delay.
// Assumes move and home requests are levels on the sequencer clock.
`timescale 1ns/100ps
module dps_motor_model #(
   parameter int DELAY = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic move_request,
   input wire logic home_search,
   output logic position_reached,
   output logic home_switch_pin
);
   int mcnt;
   int hcnt;
   // Count time on each request; answers drop one clock after the request ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mcnt <= 0;
         hcnt <= 0;
      end else begin
         mcnt <= move_request ? mcnt + 1 : 0;
         hcnt <= home_search ? hcnt + 1 : 0;
      end
   end
   assign position_reached = (mcnt >= DELAY);
   assign home_switch_pin = (hcnt >= DELAY);
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench: APB register access and positioning runs.
// Assumes the sequencer with a short tick and the motor model beside it.
`timescale 1ns/100ps
module tb_top;
   import dps_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, run_cmd = 0, position_reached, home_switch_pin, pos_enable_pin = 0;
   logic [15:0] fieldbus_target = 16'h0007;
   dps_speed_in_t speed_in = {16'h0011, 16'h0022, 16'h0033, 16'h0044, 16'h0055};
   dps_drive_t drive_out;
   logic [31:0] target_position;
   logic move_request, home_search, home_calibrate, ff_filter_active;
   logic [15:0] ff_filter_time;
   logic positioning_done, spindle_done, irq;
   int n_fail = 0, samples_checked = 0, n_home = 0, n;
   // Clock of 5 ns period
   always #2.5 pclk = ~pclk;
   // Count cycles spent searching home
   always @(posedge pclk) if (home_search === 1'b1) n_home++;
   dps_sequencer #(.TICK_DIV(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_cmd(run_cmd), .pos_enable_pin(pos_enable_pin), .home_switch_pin(home_switch_pin),
      .fieldbus_target(fieldbus_target), .position_reached(position_reached), .speed_in(speed_in),
      .drive_out(drive_out), .target_position(target_position), .move_request(move_request),
      .home_search(home_search), .home_calibrate(home_calibrate), .ff_filter_active(ff_filter_active),
      .ff_filter_time(ff_filter_time), .positioning_done(positioning_done), .spindle_done(spindle_done),
      .irq(irq));
   dps_motor_model motor_u (.pclk(pclk), .presetn(presetn), .move_request(move_request),
      .home_search(home_search), .position_reached(position_reached), .home_switch_pin(home_switch_pin));
   task results();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_fail++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait for the completion level, bounded
   task wait_done(input logic lvl);
      int i;
      for (i = 0; i < 3000 && positioning_done !== lvl; i++) @(posedge pclk);
      if (i == 3000) begin
         n_fail++;
         results();
      end
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values
      xfer(0, ADDR_MODE, 0); chk(rd, 32'h0);
      xfer(0, ADDR_ACCEL, 0); chk(rd, {16'h0, RST_ACCEL});
      xfer(0, ADDR_ARRHOLD, 0); chk(rd, {16'h0, RST_ARRHOLD});
      xfer(0, ADDR_CMPHOLD, 0); chk(rd, {16'h0, RST_CMPHOLD});
      xfer(0, ADDR_GEARNUM, 0); chk(rd, {16'h0, RST_GEAR});
      // Reserved mode bits and an unmapped address
      xfer(1, ADDR_MODE, 32'hffff); xfer(0, ADDR_MODE, 0); chk(rd, 32'h03ff);
      xfer(0, 8'hfc, 0); chk({err, rd}, {1'b1, 32'h0});
      // Gear scaling, from reference then from fieldbus
      xfer(1, ADDR_MODE, 0); xfer(1, ADDR_POSREF, 100); xfer(1, ADDR_GEARNUM, 3); xfer(1, ADDR_GEARDEN, 2);
      repeat (4) @(posedge pclk); chk(target_position, 32'd150);
      xfer(1, ADDR_MODE, 32'h0200); repeat (4) @(posedge pclk); chk(target_position, 32'd10);
      // Speed source codes 1 to 5
      for (int k = 1; k < 6; k++) begin
         xfer(1, ADDR_SPDSRC, k); repeat (4) @(posedge pclk); chk(drive_out.speed, 16'h0011 * k);
      end
      xfer(1, ADDR_SPDSRC, 0); repeat (4) @(posedge pclk); chk(drive_out.speed, RST_SPDDIG);
      chk({drive_out.accel, drive_out.ramp_time}, {1'b1, RST_ACCEL});
      // Feedforward filter only for pulse string on either select
      xfer(1, ADDR_SRCSEL, 32'h000c); repeat (3) @(posedge pclk); chk({ff_filter_active, ff_filter_time}, 17'h10064);
      xfer(1, ADDR_SRCSEL, 32'h0c00); repeat (3) @(posedge pclk); chk(ff_filter_active, 1);
      xfer(1, ADDR_SRCSEL, 32'h000b); repeat (3) @(posedge pclk); chk(ff_filter_active, 0);
      // Automatic cycle; arrival hold outlasts completion hold so the hold count ends completion
      xfer(1, ADDR_MODE, 32'h0002); xfer(1, ADDR_ARRHOLD, 10); xfer(1, ADDR_CMPHOLD, 3); xfer(1, ADDR_IRQ_EN, 7);
      run_cmd <= 1'b1;
      wait_done(1); chk(spindle_done, 1);
      n = 0;
      while (positioning_done === 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(n >= 8 && n <= 16, 1);
      chk(irq, 1);
      run_cmd <= 1'b0;
      repeat (200) @(posedge pclk);
      xfer(1, ADDR_IRQ_EN, 0); @(posedge pclk); chk(irq, 0);
      xfer(1, ADDR_IRQ_CLR, 7); xfer(0, ADDR_IRQ_STAT, 0); chk(rd, 0);
      // Second run with bit 4 clear: no new home search; completion held
      n_home = 0;
      xfer(1, ADDR_MODE, 32'h0042);
      run_cmd <= 1'b1;
      wait_done(1);
      run_cmd <= 1'b0;
      repeat (200) @(posedge pclk);
      chk({positioning_done, spindle_done}, 2'b11);
      chk(n_home, 0);
      // Bit 4 set: home search at run start
      xfer(1, ADDR_MODE, 32'h0052);
      run_cmd <= 1'b1;
      n = 0;
      while (home_calibrate !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(n < 100, 1);
      chk(n_home > 0, 1);
      run_cmd <= 1'b0;
      repeat (200) @(posedge pclk);
      // Terminal cycle: initial move, then one move on a single enable pulse
      xfer(1, ADDR_MODE, 32'h0080);
      run_cmd <= 1'b1;
      repeat (3) @(posedge pclk); chk(move_request, 1);
      repeat (60) @(posedge pclk); chk(move_request, 0);
      xfer(0, ADDR_STATE, 0); chk(rd, 32'h1b);
      pos_enable_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      pos_enable_pin <= 1'b0;
      wait_done(1); chk(spindle_done, 1);
      // Level enable held high keeps the moves coming
      xfer(1, ADDR_MODE, 32'h0180);
      pos_enable_pin <= 1'b1;
      wait_done(0); wait_done(1); wait_done(0); wait_done(1); chk(spindle_done, 1);
      results();
   end
endmodule
